/* logic/cpg_defines.svh */
// Constants of the configuration port and global register bank
// Functional notes
// RQ1: A write of the entry key to the configuration port puts the device in the configuration state.
// RQ2: In the configuration state the index port sits at the configuration port and the data port one above it.
// RQ3: Writing index 0x07 then a number on the data port latches the selected logical device number.
// RQ4: Any index from 0x30 up is passed to the selected logical device for a data port read or write.
// RQ5: Global registers below 0x30 are reached whatever logical device is selected.
// RQ6: A write of the exit key to the configuration port returns to run and stops index and data decode.
// RQ7: Only run and configuration states exist, and run always accepts a correct entry key; the code ignores it on DMA cycles (AEN high).
// RQ8: Writing one to bit 0 of config control reloads only device select, power control and clock mask.
// RQ9: After the main power-on reset all host accesses are ignored for 500 us.
// RQ10: Device identifier and revision are fixed read-only values and writes to them do nothing.
// RQ11: A strap sampled at reset picks configuration port 0x03F0 when low and 0x0370 when high.
// RQ12: The two port address bytes relocate the configuration port for all later accesses.
// RQ13: Entering or leaving configuration leaves the logical device settings untouched.
// RQ14: Unimplemented global indices read as zero and ignore writes.
`ifndef CPG_DEFINES_SVH
`define CPG_DEFINES_SVH

`define CPG_KEY_ENTER      8'h55
`define CPG_KEY_EXIT       8'hAA
`define CPG_DATA_OFS       16'h0001
`define CPG_PORT_LOW_S0    8'hF0
`define CPG_PORT_LOW_S1    8'h70
`define CPG_PORT_HIGH_RST  8'h03
`define CPG_SOFT_RST_BIT   0

`define CPG_IDX_CTRL       8'h02
`define CPG_IDX_INDEX      8'h03
`define CPG_IDX_LDN        8'h07
`define CPG_IDX_DEV_ID     8'h20
`define CPG_IDX_DEV_REV    8'h21
`define CPG_IDX_PWR_CTL    8'h22
`define CPG_IDX_PWR_MGMT   8'h23
`define CPG_IDX_OSC        8'h24
`define CPG_IDX_PORT_LOW   8'h26
`define CPG_IDX_PORT_HIGH  8'h27
`define CPG_IDX_CLK_MASK   8'h28
`define CPG_IDX_TEST4      8'h2B
`define CPG_IDX_TEST5      8'h2C
`define CPG_IDX_TEST1      8'h2D
`define CPG_IDX_LD_FIRST   8'h30

`define CPG_RST_INDEX      8'h03
`define CPG_RST_ZERO       8'h00
`define CPG_RST_OSC        8'h04

`define CPG_BLOCK_TIME_US  500
`define CPG_CLK_MHZ        100

`endif

/* logic/cpg_pkg.sv */
// Types shared by the configuration port logic
package cpg_pkg;

  typedef enum logic {
    CPG_RUN,
    CPG_CONFIG
  } cpg_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        iow_b;
    logic        ior_b;
    logic        aen;
  } cpg_isa_t;

  typedef struct packed {
    logic [7:0]  index;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cpg_ld_req_t;

  typedef struct packed {
    logic [7:0]  index_addr;
    logic [7:0]  selected_function_number;
    logic [7:0]  power_control;
    logic [7:0]  power_management;
    logic [7:0]  oscillator_control;
    logic [7:0]  port_addr_low_reg;
    logic [7:0]  port_addr_high_reg;
    logic [7:0]  clock_mask;
    logic [7:0]  test_reg_four;
    logic [7:0]  test_reg_five;
    logic [7:0]  test_reg_one;
  } cpg_glb_t;

  typedef struct packed {
    cpg_mode_t   mode;
    logic [7:0]  index;
    cpg_glb_t    glb;
    cpg_ld_req_t ld;
    logic        iow_q;
    logic        ior_q;
    logic        rd_drive;
    logic [7:0]  rd_data;
    logic        strap_pending;
  } cpg_state_t;

endpackage : cpg_pkg

/* logic/cpg_por_block.sv */
// Host access blocking timer after main power-on reset
`timescale 1ns/1ns
module cpg_por_block #(
  parameter int BLOCK_CYCLES = 50000
) (
  input  wire logic CLK,
  input  wire logic RST_B,
  output logic      READY
);
  import cpg_pkg::*;

  localparam int CW = $clog2(BLOCK_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          ready;
  } cpg_por_state_t;

  cpg_por_state_t s;
  cpg_por_state_t next_s;

  // Count only after main power-on; host bus reset does not restart it
  always_comb begin
    next_s = s;
    if (!s.ready) begin
      next_s.count = s.count + CW'(1);
      if (s.count == CW'(BLOCK_CYCLES - 1)) begin
        next_s.ready = 1'b1; // [RQ9]
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign READY = s.ready;

endmodule : cpg_por_block

/* logic/cpg_top.sv */
// Configuration port decoder and global configuration register bank
`timescale 1ns/1ns
`include "cpg_defines.svh"
module cpg_top #(
  // Block time in cycles, shortened in simulation
  parameter int         BLOCK_CYCLES = `CPG_BLOCK_TIME_US * `CPG_CLK_MHZ,
  // Arbitrary identification values
  parameter logic [7:0] DEVICE_IDENTIFIER    = 8'h5A,
  parameter logic [7:0] DEVICE_REV   = 8'h01
) (
  input  wire logic          CLK,
  input  wire logic          RST_B,
  input  wire logic          HOST_BUS_RESET_PIN,
  input  wire logic          SYSOPT_STRAP,
  input  wire cpg_pkg::cpg_isa_t ISA,
  output logic [7:0]         SD_OUT,
  output logic               SD_OE,
  input  wire logic [7:0]    LD_RDATA,
  output cpg_pkg::cpg_ld_req_t LD_REQ,
  output cpg_pkg::cpg_glb_t  GLOBAL,
  output logic               CONFIG_MODE,
  output logic               HOST_READY
);
  import cpg_pkg::*;

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  cpg_state_t s;
  cpg_state_t next_s;
  logic       ready;
  logic [15:0] data_port;
  logic        hit_cfg;
  logic        hit_data;
  logic        wr_start;
  logic        rd_start;
  logic        in_cfg;
  logic        ld_index;

  //--------------------------------------------------------------
  // Power-on block timer
  //--------------------------------------------------------------
  cpg_por_block #(
    .BLOCK_CYCLES (BLOCK_CYCLES)
  ) u_por (
    .CLK   (CLK),
    .RST_B (RST_B),
    .READY (ready)
  );

  //--------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------
  // Decode follows the live base, so a relocation acts at once
  always_comb begin
    data_port = {s.glb.port_addr_high_reg, s.glb.port_addr_low_reg} + `CPG_DATA_OFS; // [RQ2]
    hit_cfg   = (ISA.addr == {s.glb.port_addr_high_reg, s.glb.port_addr_low_reg}); // [RQ12]
    hit_data  = (ISA.addr == data_port);
    in_cfg    = (s.mode == CPG_CONFIG);
    // Strobes taken on their falling edge, once per host cycle
    wr_start  = ready && s.iow_q && !ISA.iow_b && !ISA.aen; // [RQ9]
    rd_start  = ready && s.ior_q && !ISA.ior_b && !ISA.aen; // [RQ9]
    ld_index  = (s.index >= `CPG_IDX_LD_FIRST);
  end

  //--------------------------------------------------------------
  // Global register read mux
  //--------------------------------------------------------------
  function automatic logic [7:0] glb_read(
    input cpg_glb_t   g,
    input logic [7:0] idx
  );
    logic [7:0] v;
    v = `CPG_RST_ZERO;
    unique case (idx)
      `CPG_IDX_INDEX:     v = g.index_addr;
      `CPG_IDX_LDN:       v = g.selected_function_number;
      `CPG_IDX_DEV_ID:    v = DEVICE_IDENTIFIER;  // [RQ10]
      `CPG_IDX_DEV_REV:   v = DEVICE_REV; // [RQ10]
      `CPG_IDX_PWR_CTL:   v = g.power_control;
      `CPG_IDX_PWR_MGMT:  v = g.power_management;
      `CPG_IDX_OSC:       v = g.oscillator_control;
      `CPG_IDX_PORT_LOW:  v = g.port_addr_low_reg;
      `CPG_IDX_PORT_HIGH: v = g.port_addr_high_reg;
      `CPG_IDX_CLK_MASK:  v = g.clock_mask;
      `CPG_IDX_TEST4:     v = g.test_reg_four;
      `CPG_IDX_TEST5:     v = g.test_reg_five;
      `CPG_IDX_TEST1:     v = g.test_reg_one;
      // Config control is write-only and reads as zero
      default:            v = `CPG_RST_ZERO; // [RQ14]
    endcase
    return v;
  endfunction : glb_read

  //--------------------------------------------------------------
  // Global register write
  //--------------------------------------------------------------
  function automatic cpg_glb_t glb_write(
    input cpg_glb_t   g,
    input logic [7:0] idx,
    input logic [7:0] d
  );
    cpg_glb_t r;
    r = g;
    unique case (idx)
      `CPG_IDX_CTRL: begin
        // Soft reset touches only the three soft-reset registers
        if (d[`CPG_SOFT_RST_BIT]) begin
          r.selected_function_number = `CPG_RST_ZERO; // [RQ8]
          r.power_control            = `CPG_RST_ZERO; // [RQ8]
          r.clock_mask               = `CPG_RST_ZERO; // [RQ8]
        end
      end
      `CPG_IDX_INDEX:     r.index_addr               = d;
      `CPG_IDX_LDN:       r.selected_function_number = d; // [RQ3]
      `CPG_IDX_PWR_CTL:   r.power_control            = d;
      `CPG_IDX_PWR_MGMT:  r.power_management         = d;
      `CPG_IDX_OSC:       r.oscillator_control       = d;
      `CPG_IDX_PORT_LOW:  r.port_addr_low_reg        = d; // [RQ12]
      `CPG_IDX_PORT_HIGH: r.port_addr_high_reg       = d; // [RQ12]
      `CPG_IDX_CLK_MASK:  r.clock_mask               = d;
      `CPG_IDX_TEST4:     r.test_reg_four            = d;
      `CPG_IDX_TEST5:     r.test_reg_five            = d;
      `CPG_IDX_TEST1:     r.test_reg_one             = d;
      // Identifier, revision and holes keep their value
      default:            r = g; // [RQ10] [RQ14]
    endcase
    return r;
  endfunction : glb_write

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.ld.wr  = 1'b0;
    next_s.ld.rd  = 1'b0;
    next_s.iow_q  = ISA.iow_b;
    next_s.ior_q  = ISA.ior_b;

    // Strap taken on the first edge after any reset
    if (s.strap_pending) begin
      next_s.strap_pending          = 1'b0;
      next_s.glb.port_addr_high_reg = `CPG_PORT_HIGH_RST;
      next_s.glb.port_addr_low_reg  = SYSOPT_STRAP ? `CPG_PORT_LOW_S1 : `CPG_PORT_LOW_S0; // [RQ11]
    end

    // Configuration port writes: keys and index
    if (wr_start && hit_cfg && !s.strap_pending) begin
      unique case (s.mode)
        CPG_RUN: begin
          // Anything but the entry key is ignored in run
          if (ISA.wdata == `CPG_KEY_ENTER) begin
            next_s.mode = CPG_CONFIG; // [RQ1] [RQ7]
          end
        end
        CPG_CONFIG: begin
          // The exit key cannot be used as an index
          if (ISA.wdata == `CPG_KEY_EXIT) begin
            next_s.mode = CPG_RUN; // [RQ6] [RQ13]
          end else begin
            next_s.index = ISA.wdata; // [RQ2]
          end
        end
      endcase
    end

    // Data port writes
    if (wr_start && hit_data && in_cfg && !s.strap_pending) begin // [RQ6]
      if (ld_index) begin
        next_s.ld.wr    = 1'b1; // [RQ4]
        next_s.ld.index = s.index;
        next_s.ld.wdata = ISA.wdata;
      end else begin
        next_s.glb = glb_write(s.glb, s.index, ISA.wdata); // [RQ5]
      end
    end

    // Read drive holds while the read strobe is low
    next_s.rd_drive = ready && in_cfg && !ISA.ior_b && !ISA.aen && (hit_cfg || hit_data); // [RQ2] [RQ6]

    if (rd_start && in_cfg && hit_cfg) begin
      next_s.rd_data = s.index;
    end

    if (rd_start && in_cfg && hit_data) begin
      if (ld_index) begin
        // Device answers one cycle later; data captured then
        next_s.ld.rd    = 1'b1; // [RQ4]
        next_s.ld.index = s.index;
      end else begin
        next_s.rd_data = glb_read(s.glb, s.index); // [RQ5]
      end
    end

    // Capture the logical device's answer
    if (s.ld.rd) begin
      next_s.rd_data = LD_RDATA; // [RQ4]
    end

    // Host bus reset: hard-reset values, test registers kept
    if (HOST_BUS_RESET_PIN) begin
      next_s.mode                         = CPG_RUN;
      next_s.index                        = `CPG_RST_ZERO;
      next_s.ld                           = '0;
      next_s.rd_drive                     = 1'b0;
      next_s.rd_data                      = `CPG_RST_ZERO;
      next_s.strap_pending                = 1'b1; // [RQ11]
      next_s.glb.index_addr               = `CPG_RST_INDEX;
      next_s.glb.selected_function_number = `CPG_RST_ZERO;
      next_s.glb.power_control            = `CPG_RST_ZERO;
      next_s.glb.power_management         = `CPG_RST_ZERO;
      next_s.glb.oscillator_control       = `CPG_RST_OSC;
      next_s.glb.clock_mask               = `CPG_RST_ZERO;
    end
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------
  // Reset port base is the strap-low value until the strap loads
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s.mode                         <= CPG_RUN;
      s.index                        <= `CPG_RST_ZERO;
      s.ld                           <= '0;
      s.iow_q                        <= 1'b1;
      s.ior_q                        <= 1'b1;
      s.rd_drive                     <= 1'b0;
      s.rd_data                      <= `CPG_RST_ZERO;
      s.strap_pending                <= 1'b1;
      s.glb.index_addr               <= `CPG_RST_INDEX;
      s.glb.selected_function_number <= `CPG_RST_ZERO;
      s.glb.power_control            <= `CPG_RST_ZERO;
      s.glb.power_management         <= `CPG_RST_ZERO;
      s.glb.oscillator_control       <= `CPG_RST_OSC;
      s.glb.port_addr_low_reg        <= `CPG_PORT_LOW_S0;
      s.glb.port_addr_high_reg       <= `CPG_PORT_HIGH_RST;
      s.glb.clock_mask               <= `CPG_RST_ZERO;
      s.glb.test_reg_four            <= `CPG_RST_ZERO;
      s.glb.test_reg_five            <= `CPG_RST_ZERO;
      s.glb.test_reg_one             <= `CPG_RST_ZERO;
    end else begin
      s <= next_s;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  // Logical device settings never depend on the mode
  assign GLOBAL      = s.glb; // [RQ13]
  assign LD_REQ      = s.ld;
  assign SD_OUT      = s.rd_data;
  assign SD_OE       = s.rd_drive;
  assign CONFIG_MODE = in_cfg;
  assign HOST_READY  = ready;

endmodule : cpg_top

/* bench/cpg_top_properties.sv */
// Checker of the configuration port decode and global registers
`timescale 1ns/1ns
module cpg_top_properties #(
  parameter int         BLOCK_CYCLES = 50000,
  parameter logic [7:0] DEVICE_IDENTIFIER    = 8'h5A,
  parameter logic [7:0] DEVICE_REV   = 8'h01
) (
  input wire logic                 CLK,
  input wire logic                 RST_B,
  input wire logic                 HOST_BUS_RESET_PIN,
  input wire logic                 SYSOPT_STRAP,
  input wire cpg_pkg::cpg_isa_t    ISA,
  input wire logic [7:0]           SD_OUT,
  input wire logic                 SD_OE,
  input wire logic [7:0]           LD_RDATA,
  input wire cpg_pkg::cpg_ld_req_t LD_REQ,
  input wire cpg_pkg::cpg_glb_t    GLOBAL,
  input wire logic                 CONFIG_MODE,
  input wire logic                 HOST_READY
);
  import cpg_pkg::*;
  // ----------------------------------------
  // Shadow of the host cycle decode
  // ----------------------------------------
  logic        iow_q;
  logic        ior_q;
  logic        pend;
  logic [7:0]  idx;
  int          cnt;
  wire  [15:0] base = {GLOBAL.port_addr_high_reg, GLOBAL.port_addr_low_reg};
  // Strap load edge after any reset refuses the access
  wire         go   = !ISA.aen && HOST_READY && !pend;
  wire         tk_w = iow_q && !ISA.iow_b && go;
  wire         tk_r = ior_q && !ISA.ior_b && go;
  wire         at_i = ISA.addr == base;
  wire         at_d = ISA.addr == base + 16'h0001;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      iow_q <= 1'b1;
      ior_q <= 1'b1;
      pend  <= 1'b1;
      idx   <= 8'h00;
      cnt   <= 0;
    end else begin
      iow_q <= ISA.iow_b;
      ior_q <= ISA.ior_b;
      pend  <= HOST_BUS_RESET_PIN;
      if (cnt < BLOCK_CYCLES + 2) begin
        cnt <= cnt + 1;
      end
      if (HOST_BUS_RESET_PIN) begin
        idx <= 8'h00;
      end else if (tk_w && CONFIG_MODE && at_i && ISA.wdata != 8'hAA) begin
        idx <= ISA.wdata;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B || HOST_BUS_RESET_PIN);
  sequence s_wd;
    tk_w && CONFIG_MODE && at_d;
  endsequence
  sequence s_rd;
    tk_r && CONFIG_MODE && at_d;
  endsequence
  AST_ENTER: assert property (tk_w && !CONFIG_MODE && at_i && ISA.wdata == 8'h55 |=> CONFIG_MODE)
    else $error("entry key did not enter configuration");
  AST_EXIT: assert property (tk_w && CONFIG_MODE && at_i && ISA.wdata == 8'hAA |=> !CONFIG_MODE)
    else $error("exit key did not leave configuration");
  AST_RUN_QUIET: assert property (!CONFIG_MODE && !$past(CONFIG_MODE) |-> !SD_OE && !LD_REQ.wr && !LD_REQ.rd)
    else $error("port decoded in run state");
  AST_BLOCKED: assert property (!HOST_READY |-> !CONFIG_MODE && !SD_OE)
    else $error("access answered during blocking time");
  AST_READY_TIME: assert property ($rose(HOST_READY) |-> cnt >= BLOCK_CYCLES - 1 && cnt <= BLOCK_CYCLES + 1)
    else $error("blocking time has wrong length");
  AST_LDN: assert property (s_wd ##0 idx == 8'h07 |=> GLOBAL.selected_function_number == $past(ISA.wdata))
    else $error("device number not latched");
  AST_ID: assert property (s_rd ##0 idx == 8'h20 |=> SD_OE && SD_OUT == DEVICE_IDENTIFIER)
    else $error("identifier read wrong");
  AST_REV: assert property (s_rd ##0 idx == 8'h21 |=> SD_OE && SD_OUT == DEVICE_REV)
    else $error("revision read wrong");
  AST_STRAP: assert property ($fell(HOST_BUS_RESET_PIN) |=> GLOBAL.port_addr_low_reg ==
    ($past(SYSOPT_STRAP) ? 8'h70 : 8'hF0)) else $error("port low byte not taken from strap");
  AST_LD_WR: assert property (s_wd ##0 idx >= 8'h30 |=> LD_REQ.wr && LD_REQ.index == $past(idx))
    else $error("device register write not passed on");
  AST_LD_RD: assert property (s_rd ##0 idx >= 8'h30 |=> LD_REQ.rd ##1 SD_OUT == $past(LD_RDATA))
    else $error("device register read not returned");
  AST_SOFT: assert property (s_wd ##0 idx == 8'h02 && ISA.wdata[0] |=> GLOBAL.clock_mask == 8'h00
    && GLOBAL.power_control == 8'h00 && GLOBAL.selected_function_number == 8'h00
    && $stable(GLOBAL.power_management)) else $error("soft reset wrong");
  AST_RELOC: assert property (s_wd ##0 idx == 8'h26 |=> GLOBAL.port_addr_low_reg == $past(ISA.wdata))
    else $error("port low byte not written");
endmodule : cpg_top_properties

bind cpg_top cpg_top_properties #(.BLOCK_CYCLES(BLOCK_CYCLES), .DEVICE_IDENTIFIER(DEVICE_IDENTIFIER), .DEVICE_REV(DEVICE_REV))
  u_props (.CLK(CLK), .RST_B(RST_B), .HOST_BUS_RESET_PIN(HOST_BUS_RESET_PIN), .SYSOPT_STRAP(SYSOPT_STRAP),
  .ISA(ISA), .SD_OUT(SD_OUT), .SD_OE(SD_OE), .LD_RDATA(LD_RDATA), .LD_REQ(LD_REQ), .GLOBAL(GLOBAL),
  .CONFIG_MODE(CONFIG_MODE), .HOST_READY(HOST_READY));

/* bench/cpg_host_model.sv */
// Host processor model issuing I/O cycles
`timescale 1ns/1ns
module cpg_host_model (
  input wire logic           clk,
  output cpg_pkg::cpg_isa_t  isa
);
  import cpg_pkg::*;
  initial isa = '{addr: 16'h0000, wdata: 8'h00, iow_b: 1'b1, ior_b: 1'b1, aen: 1'b0};
  // Strobe held 3 cycles, then high two cycles before the next one
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic dma);
    @(posedge clk);
    isa.addr  <= a;
    isa.wdata <= d;
    isa.aen   <= dma;
    isa.iow_b <= !wr;
    isa.ior_b <= wr;
    repeat (3) @(posedge clk);
    isa.iow_b <= 1'b1;
    isa.ior_b <= 1'b1;
    @(posedge clk);
    // Released bus shows no stale value
    isa.wdata <= ~d;
    isa.addr  <= ~a;
  endtask : io
endmodule : cpg_host_model

/* bench/tb.sv */
// Self-checking bench for the configuration port and global registers
`timescale 1ns/1ns
module tb;
  import cpg_pkg::*;
  localparam int         BLK = 20;
  localparam logic [7:0] ID  = 8'h5A;  // Arbitrary value
  localparam logic [7:0] REV = 8'h3C;  // Arbitrary value
  logic        clk = 1'b0, rst_b = 1'b0, hard_rst = 1'b0, strap = 1'b0, oe_q = 1'b0;
  logic [7:0]  ld_rdata = 8'h00, sd_out, r;
  logic        sd_oe, cfg, rdy;
  cpg_isa_t    isa;
  cpg_ld_req_t ld_req;
  cpg_glb_t    glb, snap;
  logic [7:0]  m [256];
  logic [7:0]  exp_q [$];
  logic [31:0] seed = 32'h0000002B;
  logic [15:0] base;
  int          failures = 0, total_checks = 0, cycles = 0;
  always #5 clk = ~clk;
  cpg_host_model host (.clk(clk), .isa(isa));
  cpg_top #(.BLOCK_CYCLES(BLK), .DEVICE_IDENTIFIER(ID), .DEVICE_REV(REV)) dut (.CLK(clk), .RST_B(rst_b),
    .HOST_BUS_RESET_PIN(hard_rst), .SYSOPT_STRAP(strap), .ISA(isa), .SD_OUT(sd_out), .SD_OE(sd_oe),
    .LD_RDATA(ld_rdata), .LD_REQ(ld_req), .GLOBAL(glb), .CONFIG_MODE(cfg), .HOST_READY(rdy));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk
  task automatic defaults(input logic por);
    if (por) for (int k = 0; k < 256; k++) m[k] = 8'h00;
    {m[8'h20], m[8'h21], m[8'h03], m[8'h24], m[8'h27]} = {ID, REV, 8'h03, 8'h04, 8'h03};
    {m[8'h07], m[8'h22], m[8'h23], m[8'h28]} = 32'h0;
    m[8'h26] = strap ? 8'h70 : 8'hF0;
    base = {m[8'h27], m[8'h26]};
  endtask : defaults
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host.io(1'b1, base, i, 1'b0);
    host.io(1'b1, base + 16'h0001, d, 1'b0);
    if (i inside {8'h03, 8'h07, [8'h22:8'h24], [8'h26:8'h28], [8'h2B:8'h2D]}) m[i] = d;
    if (i == 8'h02 && d[0]) {m[8'h07], m[8'h22], m[8'h28]} = 24'h0;
    base = {m[8'h27], m[8'h26]};
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    host.io(1'b1, base, i, 1'b0);
    exp_q.push_back(e);
    host.io(1'b0, base + 16'h0001, 8'h00, 1'b0);
  endtask : rd
  task automatic sweep();
    for (int k = 0; k < 8'h30; k++) rd(8'(k), m[k]);
  endtask : sweep
  task automatic print_verdict();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Read result monitor and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    oe_q <= sd_oe;
    if (oe_q === 1'b1 && sd_oe === 1'b0) chk("read data", exp_q.size() ? exp_q.pop_front() : 8'hXX, sd_out);
    cycles++;
    if (cycles == 8000) begin
      failures++;
      $display("unexpected timeout: expected end, seen %0d cycles", cycles);
      print_verdict();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    defaults(1'b1);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    host.io(1'b1, base, 8'h55, 1'b0);
    chk("mode before ready", 8'h00, {7'h00, cfg});
    chk("ready before block time", 8'h00, {7'h00, rdy});
    for (int k = 0; k < 100 && rdy !== 1'b1; k++) @(posedge clk);
    chk("ready after block time", 8'h01, {7'h00, rdy});
    host.io(1'b1, base, 8'h55, 1'b1);
    chk("mode after dma cycle", 8'h00, {7'h00, cfg});
    host.io(1'b1, base, 8'h55, 1'b0);
    chk("mode after entry", 8'h01, {7'h00, cfg});
    sweep();
    for (int k = 0; k < 8'h30; k++) if (k != 8'h26 && k != 8'h27) wr(8'(k), rnd());
    sweep();
    wr(8'h07, 8'h05);
    rd(8'h20, ID);
    r = rnd();
    wr(8'hF0, r);
    chk("device index", 8'hF0, ld_req.index);
    chk("device data", r, ld_req.wdata);
    r = rnd();
    ld_rdata <= r;
    rd(8'hF1, r);
    ld_rdata <= ~r;
    wr(8'h02, 8'h01);
    sweep();
    wr(8'h26, 8'h60);
    rd(8'h26, 8'h60);
    exp_q.push_back(8'h26);
    host.io(1'b0, base, 8'h00, 1'b0);
    snap = glb;
    host.io(1'b1, base, 8'hAA, 1'b0);
    chk("mode after exit", 8'h00, {7'h00, cfg});
    host.io(1'b0, base + 16'h0001, 8'h00, 1'b0);
    host.io(1'b1, 16'h03F0, 8'h55, 1'b0);
    chk("mode after old port", 8'h00, {7'h00, cfg});
    host.io(1'b1, base, 8'h55, 1'b0);
    chk("mode after reentry", 8'h01, {7'h00, cfg});
    chk("globals changed", 8'h00, {7'h00, glb !== snap});
    strap <= 1'b1;
    hard_rst <= 1'b1;
    @(posedge clk);
    hard_rst <= 1'b0;
    repeat (2) @(posedge clk);
    defaults(1'b0);
    chk("mode after hard reset", 8'h00, {7'h00, cfg});
    chk("ready after hard reset", 8'h01, {7'h00, rdy});
    host.io(1'b1, 16'h0370, 8'h55, 1'b0);
    sweep();
    // Last read is compared two edges after its strobe rises
    repeat (2) @(posedge clk);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    print_verdict();
  end
endmodule : tb
